// ### core/cfs_consts.vh
// Constants for the converter function status block
`ifndef CFS_CONSTS_VH
`define CFS_CONSTS_VH
`define CFS_ADDR_GENERAL_STATUS 4'h8
`define CFS_ADDR_FUNC_STATUS 4'hF
`define CFS_RST_GENERAL_STATUS 16'h0004
`define CFS_RST_FUNC_STATUS 16'h0000
`define CFS_BIT_DRV_XX 13
`define CFS_BIT_DRV_YY 14
`define CFS_BIT_DRV_YX 15
`define CFS_FUNC_BITS 9
`define CFS_SCAN_LAST_CODE 4'h1
`endif

// ### core/cfs_driver_decode.v
// Touch driver pair decoder for the converter function status block
`timescale 1ns/10ps
`default_nettype none
module cfs_driver_decode (
    input wire i_clk,
    input wire i_rst,
    input wire i_clear,
    input wire i_xp_on,
    input wire i_xn_on,
    input wire i_yp_on,
    input wire i_yn_on,
    output reg [2:0] o_pairs
);
    reg [2:0] pairs_next;
    // Pair decode; other combinations give zero
    always @* begin
        pairs_next = 3'h0;
        pairs_next[0] = i_xp_on & i_xn_on;
        pairs_next[1] = i_yp_on & i_yn_on;
        pairs_next[2] = i_yp_on & i_xn_on;
        if (i_clear) begin
            pairs_next = 3'h0;
        end
    end
    // Registered pair flags, zero otherwise
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_pairs <= 3'h0;
        end else begin
            o_pairs <= pairs_next;
        end
    end
endmodule
`default_nettype wire

// ### core/cfs_status.v
// Converter function status and general status registers
// Behaviour
// - Bit 13 set while both X drivers are on.
// - Bit 14 set while both Y drivers are on.
// - Bit 15 set while Y plus and X minus drivers are on.
// - Any other driver combination leaves driver bits at zero.
// - Driver bits clear on completion, stop, hardware or software reset.
// - Running function sets the bit indexed by its select code.
// - Function bits clear on completion, stop, hardware or software reset.
// - Scan mode keeps bit 0 or 1 set when completing without touch.
// - Scan mode restarts scanning at next pen touch while bit held.
// - General status sits at address 8, resets to 0004h.
`timescale 1ns/10ps
`default_nettype none
`include "cfs_consts.vh"
//////////////////////////////////////////////////////////////////////
// Register layout at the function address
//   15     : Y plus with X minus on, pressure pair
//   14     : both Y drivers on
//   13     : both X drivers on
//   12..9  : reserved, always zero
//   8..0   : one-hot running function
// Codes above 8 set no function bit at all
// General status address
//   Whole word follows the status input one cycle late
//   Reset value held until the first capture after release
// Clearing
//   Stop, software reset and reset clear every flag
//   Completion clears too, except a kept scan bit
//   A start in the same cycle as a clear other than reset still loads its bit
//   Driver bits drop for one cycle on any clear
// Scan mode
//   Completion without a touch keeps bit 0 or 1
//   A touch seen at completion lets the bit clear
//   A later pen touch edge pulses the restart output
//   Touch edge seen two cycles after the pin rises
//   No restart pulse in a cycle that starts, stops or resets
// Host side
//   Read data registered, stands until the next read
//   Unmapped addresses read as zero
//   Writes reach no register at all
// Hazards
//   Pen pin is asynchronous, two flops before any use
//   Driver levels share this clock, no synchroniser
//////////////////////////////////////////////////////////////////////
module cfs_status (
    input wire i_clk,
    input wire i_rst,
    input wire i_sw_reset,
    input wire i_stop,
    input wire i_func_start,
    input wire [3:0] i_function_select_code,
    input wire i_func_done,
    input wire i_scan_mode_select,
    input wire i_pen_touch,
    input wire i_xp_on,
    input wire i_xn_on,
    input wire i_yp_on,
    input wire i_yn_on,
    input wire [15:0] i_general_status_in,
    input wire i_rd_en,
    input wire [3:0] i_rd_addr,
    input wire i_wr_en,
    input wire [15:0] i_wr_data,
    output reg [15:0] o_rd_data,
    output reg o_scan_restart
);
    ////////////////////////////////////////////////////////////////
    reg pen_s1_reg;
    reg pen_s2_reg;
    reg pen_prev_reg;
    reg [8:0] func_reg;
    reg [8:0] func_next;
    reg restart_next;
    reg [15:0] gen_reg;
    wire clear_all;
    wire pen_rise;
    wire [2:0] pairs;
    wire scan_held;
    // Field layout of the function status word
    localparam [3:0] RSVD_ZERO = 4'h0;
    localparam [8:0] SCAN_KEEP_MASK = 9'h003;
    reg [15:0] rd_data_next;
    wire [15:0] func_word;
    wire kept_done;

    // One-hot from select code; codes above 8 map to nothing
    function [8:0] code_onehot;
        input [3:0] code;
        begin
            code_onehot = 9'h000;
            if (code <= 4'h8) begin
                code_onehot = 9'h001 << code;
            end
        end
    endfunction

    assign clear_all = i_rst | i_sw_reset | i_stop;
    assign pen_rise = pen_s2_reg & ~pen_prev_reg;
    assign scan_held = i_scan_mode_select & (func_reg[0] | func_reg[1]);
    // Completion in scan mode with no touch keeps the scan bit
    assign kept_done = i_func_done & i_scan_mode_select & ~i_pen_touch_held(func_reg);
    // Word seen by the host at the function address
    assign func_word = {pairs, RSVD_ZERO, func_reg};

    ////////////////////////////////////////////////////////////////
    // Pen touch pin synchroniser and edge memory
    always @(posedge i_clk) begin
        if (i_rst) begin
            pen_s1_reg <= 1'b0;
            pen_s2_reg <= 1'b0;
            pen_prev_reg <= 1'b0;
        end else begin
            pen_s1_reg <= i_pen_touch;
            pen_s2_reg <= pen_s1_reg;
            pen_prev_reg <= pen_s2_reg;
        end
    end

    cfs_driver_decode u_drv (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_clear(i_sw_reset | i_stop | i_func_done),
        .i_xp_on(i_xp_on),
        .i_xn_on(i_xn_on),
        .i_yp_on(i_yp_on),
        .i_yn_on(i_yn_on),
        .o_pairs(pairs)
    );

    ////////////////////////////////////////////////////////////////
    // Function flag next state; clears first, a start overrides
    always @* begin
        func_next = func_reg;
        if (clear_all) begin
            func_next = 9'h000;
        end else if (kept_done) begin
            func_next = func_reg & SCAN_KEEP_MASK;
        end else if (i_func_done) begin
            func_next = 9'h000;
        end
        // Set wins against done, stop and software reset
        if (i_func_start && !i_rst) begin
            func_next = code_onehot(i_function_select_code);
        end
    end

    // Restart pulse while a scan bit is held and the pen lands
    always @* begin
        restart_next = 1'b0;
        if (scan_held && pen_rise && !i_func_start) begin
            restart_next = 1'b1;
        end
        if (clear_all) begin
            restart_next = 1'b0;
        end
    end

    // Scan bits only persist when no touch ended the function
    function i_pen_touch_held;
        input [8:0] flags;
        begin
            i_pen_touch_held = pen_s2_reg | ~(flags[0] | flags[1]);
        end
    endfunction

    ////////////////////////////////////////////////////////////////
    // Flag registers and general status capture
    always @(posedge i_clk) begin
        if (i_rst) begin
            func_reg <= 9'h000;
            o_scan_restart <= 1'b0;
            gen_reg <= `CFS_RST_GENERAL_STATUS;
        end else begin
            func_reg <= func_next;
            o_scan_restart <= restart_next;
            gen_reg <= i_general_status_in;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Read mux; writes have no path into any register
    always @* begin
        case (i_rd_addr)
            `CFS_ADDR_GENERAL_STATUS: begin
                rd_data_next = gen_reg;
            end
            `CFS_ADDR_FUNC_STATUS: begin
                rd_data_next = func_word;
            end
            default: begin
                rd_data_next = 16'h0000;
            end
        endcase
    end

    // Read data register; holds between reads
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_rd_data <= 16'h0000;
        end else if (i_rd_en) begin
            o_rd_data <= rd_data_next;
        end
    end
endmodule
`default_nettype wire

// ### testbench/cfs_status_asserts.sv
// Checker for the function status register
`timescale 1ns/10ps
`default_nettype none
module cfs_status_asserts (
    input wire i_clk,
    input wire i_rst,
    input wire i_stop,
    input wire i_sw_reset,
    input wire i_func_done,
    input wire i_func_start,
    input wire [3:0] i_function_select_code,
    input wire i_xp_on,
    input wire i_xn_on,
    input wire i_yp_on,
    input wire i_yn_on,
    input wire i_rd_en,
    input wire [3:0] i_rd_addr,
    input wire [15:0] o_rd_data,
    input wire o_scan_restart
);
    // Function register read and any clear
    wire rf = i_rd_en && i_rd_addr == 4'hF;
    wire cl = i_stop | i_sw_reset | i_func_done | i_rst;
    wire [2:0] pr = {i_yp_on & i_xn_on, i_yp_on & i_yn_on, i_xp_on & i_xn_on};
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_rsvd_zero: assert property (rf |=> o_rd_data[12:9] == 4'h0)
        else $error("reserved bits set");
    a_pair_bits: assert property (rf && $past(!cl) |=> o_rd_data[15:13] == $past(pr, 2))
        else $error("driver pair bits wrong");
    a_drv_clear: assert property (rf && $past(cl) |=> o_rd_data[15:13] == 3'h0)
        else $error("driver bits not cleared");
    a_func_bit: assert property (rf && $past(i_func_start && !cl)
        |=> o_rd_data[8:0] == 9'h001 << $past(i_function_select_code, 2))
        else $error("function bit wrong");
    a_func_clear: assert property (rf && $past((i_stop | i_sw_reset) & ~i_func_start)
        |=> o_rd_data[8:0] == 9'h000)
        else $error("function bits not cleared");
    a_reset_val: assert property ($past(i_rst) && i_rd_en && i_rd_addr == 4'h8 |=> o_rd_data == 16'h0004)
        else $error("general status reset value");
    a_unmapped_zero: assert property (i_rd_en && i_rd_addr != 4'h8 && !rf |=> o_rd_data == 16'h0000)
        else $error("unmapped read not zero");
    a_read_hold: assert property (!i_rd_en |=> $stable(o_rd_data))
        else $error("read data moved");
    // Main scenarios
    c_pair: cover property (rf && $past(i_yp_on & i_xn_on));
    c_start: cover property (i_func_start);
    c_stop: cover property (i_stop);
    c_restart: cover property (o_scan_restart);
endmodule
bind cfs_status cfs_status_asserts i_cfs_status_asserts (.*);
`default_nettype wire

// ### testbench/cfs_host.sv
// Host register reader model
`timescale 1ns/10ps
`default_nettype none
module cfs_host (
    input wire i_clk,
    input wire [15:0] i_rd_data,
    output logic o_rd_en = 1'b0,
    output logic [3:0] o_rd_addr = 4'h0
);
    // One read, held to the taking edge
    task rd(input logic [3:0] a, output logic [15:0] d);
        o_rd_en = 1'b1;
        o_rd_addr = a;
        @(posedge i_clk);
        #1 o_rd_en = 1'b0;
        d = i_rd_data;
        @(posedge i_clk);
        #1;
    endtask
endmodule
`default_nettype wire

// ### testbench/converter_function_status_test.sv
// Self-checking bench for the function status register
`timescale 1ns/10ps
`default_nettype none
module converter_function_status_test;
    logic clk = 1'b0, rst = 1'b1, swr = 1'b0, stp = 1'b0, st = 1'b0, dn = 1'b0, scn = 1'b0;
    logic pen = 1'b0, we = 1'b1, sr;
    logic [3:0] cd = 4'h0, dv = 4'h0;
    logic [15:0] gs = 16'h1234, wd = 16'h0000, rd, d, e;
    logic [22:0] r;
    wire re;
    wire [3:0] ra;
    integer n_errors = 0, total_checks = 0, cyc = 0, i, k, op, f;
    cfs_status i_cfs_status (.i_clk(clk), .i_rst(rst), .i_sw_reset(swr), .i_stop(stp),
        .i_func_start(st), .i_function_select_code(cd), .i_func_done(dn),
        .i_scan_mode_select(scn), .i_pen_touch(pen), .i_xp_on(dv[0]), .i_xn_on(dv[1]),
        .i_yp_on(dv[2]), .i_yn_on(dv[3]), .i_general_status_in(gs), .i_rd_en(re),
        .i_rd_addr(ra), .i_wr_en(we), .i_wr_data(wd), .o_rd_data(rd), .o_scan_restart(sr));
    cfs_host i_cfs_host (.i_clk(clk), .i_rd_data(rd), .o_rd_en(re), .o_rd_addr(ra));
    always #5 clk = ~clk;
    // Hang guard
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc > 5000) begin
            n_errors++;
            end_sim;
        end
    end
    task chk(input string n, input logic [15:0] x, input logic [15:0] g);
        total_checks++;
        if (x !== g) begin
            n_errors++;
            $display("MISMATCH %s exp %h got %h", n, x, g);
        end
    endtask
    task end_sim;
        $display("errors %0d checks %0d", n_errors, total_checks);
        if (n_errors == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Start, read, clear, read; scan restart when a bit is kept
    initial begin
        void'($urandom(32'hA373));
        repeat (6) @(posedge clk);
        #1 rst = 1'b0;
        i_cfs_host.rd(4'h8, d);
        chk("reset", 16'h0004, d);
        for (i = 0; i < 60; i++) begin
            {dv, cd, scn, r} = $urandom;
            {gs, wd} = $urandom;
            if (i % 10 == 0) begin
                scn = 1'b1;
                cd = 4'(i / 10 % 2);
            end
            st = 1'b1;
            @(posedge clk);
            #1 st = 1'b0;
            f = cd < 9 ? 1 << cd : 0;
            e = {dv[2] & dv[1], dv[2] & dv[3], dv[0] & dv[1], 4'h0, f[8:0]};
            i_cfs_host.rd(4'hF, d);
            chk("func", e, d);
            i_cfs_host.rd(4'h8, d);
            chk("general", gs, d);
            k = r % 14;
            i_cfs_host.rd(k < 8 ? k : k + 1, d);
            chk("unmapped", 16'h0000, d);
            op = (i % 10 == 0) ? 0 : $urandom % 3;
            dn = op == 0;
            stp = op == 1;
            swr = op == 2;
            dv = 4'h0;
            @(posedge clk);
            #1 {dn, stp, swr} = 3'h0;
            f = (op == 0 && scn && cd < 2) ? f : 0;
            i_cfs_host.rd(4'hF, d);
            chk("clear", f[15:0], d);
            if (f != 0) begin
                pen = 1'b1;
                k = 0;
                repeat (6) begin
                    @(posedge clk);
                    #1 k = k | sr;
                end
                chk("restart", 16'h0001, k[15:0]);
                pen = 1'b0;
                stp = 1'b1;
                @(posedge clk);
                #1 stp = 1'b0;
            end
        end
        end_sim;
    end
endmodule
`default_nettype wire
